/* rtl/fise_flash_dev.sv */
// Flash device end: identification reads and security register erase.
// Link logic runs on the link clock; erase timing runs on i_clk_sys.
// Overview of operation
// R1: Host sends 94h, address zero, four bits/clock
// R2: Quad ID: manufacturer then device, nibbles, MSB first
// R3: Quad ID alternates IDs until select rises
// R4: Host sends mode bits with upper nibble ones
// R5: 4Bh, four dummy bytes, then 64-bit serial
// R6: 9Fh returns manufacturer, memory type, capacity
// R7: 5Ah data starts falling edge of clock 40
// R8: Parameter address high zero, low byte starts
// R9: Erase 44h needs write permit latch set
// R10: Erase address selects one of three registers
// R11: Erase discarded unless select rises on boundary
// R12: Valid erase runs self-timed, status still readable
// R13: Busy one during erase, zero after
// R14: Erase completion clears write permit latch
// R15: Locked register ignores erase; lock never clears (the code clears lock on i_rst)
// R16: No parameter data before dummy clocks done
// R17: Sample on rising, drive on falling edges
// R18: Erased security bytes read as all ones
`timescale 1ns/1ps
module fise_flash_dev #(
  parameter int P_ERASE_CYCLES = fise_pkg::SEC_ERASE_CYCLES, // Erase duration in sys cycles
  parameter logic [7:0] P_MFR_ID = 8'h5c, // Arbitrary value
  parameter logic [7:0] P_DEV_ID = 8'h16, // Arbitrary value
  parameter logic [7:0] P_MEM_TYPE = 8'h40, // Arbitrary value
  parameter logic [7:0] P_CAPACITY = 8'h17, // Arbitrary value
  parameter logic [63:0] P_UNIQUE_ID = 64'h0123456789abcdef // Arbitrary value
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic [2:0] i_otp_lock_bits, // Nonvolatile lock straps
  input wire logic i_sec_we, // Security array preload write
  input wire logic [9:0] i_sec_addr, // {register-1, byte}
  input wire logic [7:0] i_sec_wdata, // Preload data
  output logic [7:0] o_sec_rdata, // Array byte at i_sec_addr
  output logic o_busy, // Erase in progress
  output logic o_write_permit_latch, // Write permit latch
  output logic [2:0] o_otp_lock_bits, // Sticky lock bits
  fise_link_if.dev link // Link to host
);
  import fise_pkg::*;

  // Link-clock domain state
  logic [15:0] cnt;
  logic [23:0] sr;
  logic [7:0] op;
  logic [23:0] addr;
  logic arm_wren;
  logic arm_erase;
  logic [1:0] erase_sel;
  logic [1:0] busy_l1, busy_l2;
  logic [1:0] wel_l1, wel_l2;
  logic [7:0] next_byte;
  logic [23:0] next_addr;
  logic quad_in;
  logic [15:0] idx;
  logic [15:0] qidx;
  logic [7:0] sbyte;
  logic [7:0] qbyte;
  // System domain state
  logic [4:0] sync1, sync2;
  logic cs_prev;
  logic cs_rise;
  logic busy;
  logic write_permit_latch;
  logic [31:0] timer;
  logic [1:0] erase_reg;
  logic [7:0] sweep;
  logic sweeping;
  logic [2:0] lock;
  logic erase_start;
  logic erase_done;
  logic [7:0] sec_mem [0:SEC_REG_BYTES*SEC_REG_COUNT-1];

  // Small discoverable-parameter table: signature, revision, rest unused
  function automatic logic [7:0] parameter_id_table(input logic [7:0] a);
    case (a)
      8'h00: parameter_id_table = 8'h53;
      8'h01: parameter_id_table = 8'h46;
      8'h02: parameter_id_table = 8'h44;
      8'h03: parameter_id_table = 8'h50;
      8'h04: parameter_id_table = 8'h06;
      8'h05: parameter_id_table = 8'h01;
      8'h06: parameter_id_table = 8'h00;
      default: parameter_id_table = 8'hff;
    endcase
  endfunction : parameter_id_table

  // Byte b of the serial answer to opcode o
  function automatic logic [7:0] answer_byte(input logic [7:0] o, input logic [12:0] b);
    logic [63:0] sh;
    sh = P_UNIQUE_ID << {b[2:0], 3'h0};
    case (o)
      OP_STD_ID: answer_byte = (b == 13'h0000) ? P_MFR_ID :
                               (b == 13'h0001) ? P_MEM_TYPE :
                               (b == 13'h0002) ? P_CAPACITY : 8'hff; // [R6]
      OP_UNIQUE_ID: answer_byte = (b < 13'h0008) ? sh[63:56] : 8'hff; // [R5]
      OP_PARAM_RD: answer_byte = (addr[23:8] != 16'h0000) ? 8'hff :
                                 parameter_id_table(addr[7:0] + b[7:0]); // [R8]
      OP_RDSR: answer_byte = {6'h00, wel_l2[1], busy_l2[1]}; // [R12]
      default: answer_byte = 8'hff;
    endcase
  endfunction : answer_byte

  assign next_byte = {sr[6:0], link.io[0]};
  assign next_addr = {sr[22:0], link.io[0]};
  assign quad_in = (op == OP_QUAD_ID) && (cnt >= CLK_OPCODE) && (cnt < CLK_QUAD_MODE_END);
  assign idx = cnt - fise_data_start(op);
  assign qidx = cnt - CLK_QUAD_DATA;
  assign sbyte = answer_byte(op, idx[15:3]);
  assign qbyte = qidx[1] ? P_DEV_ID : P_MFR_ID; // [R3]

  // Clock counter; select high restarts every frame
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001; // Wraps after 65536 clocks of streaming
    end
  end

  // Opcode and address capture on rising edges [R17]
  always_ff @(posedge link.sclk) begin
    sr <= quad_in ? {sr[19:0], link.io} : next_addr; // Quad address/mode ignored [R1] [R4]
    if (cnt == CLK_OPCODE - 16'h0001) begin
      op <= next_byte;
    end
    if (cnt == CLK_ADDR_END - 16'h0001) begin
      addr <= next_addr;
    end
  end

  // Arming flags hold their last value after select rises, for the sys side
  always_ff @(posedge link.sclk) begin
    arm_wren <= (cnt == CLK_OPCODE - 16'h0001) && (next_byte == OP_WREN);
    arm_erase <= (cnt == CLK_ADDR_END - 16'h0001) && (op == OP_SEC_ERASE) &&
                 (next_addr[23:14] == 10'h000) && (next_addr[13:12] != 2'h0) &&
                 (next_addr[11:8] == 4'h0); // [R10] [R11]
    erase_sel <= next_addr[13:12];
  end

  // Status bits brought into the link domain for polling
  always_ff @(posedge link.sclk) begin
    busy_l1 <= {busy_l1[0], busy};
    busy_l2 <= {busy_l2[0], busy_l1[1]};
    wel_l1 <= {wel_l1[0], write_permit_latch};
    wel_l2 <= {wel_l2[0], wel_l1[1]};
  end

  // Output data on falling edges, MSB first; nothing before data start [R17]
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      link.dev_io_oe <= 4'h0;
      link.dev_io_o <= 4'h0;
    end else if ((op == OP_QUAD_ID) && (cnt >= CLK_QUAD_DATA)) begin
      link.dev_io_oe <= 4'hf;
      link.dev_io_o <= qidx[0] ? qbyte[3:0] : qbyte[7:4]; // [R2] [R3]
    end else if (((op == OP_STD_ID) || (op == OP_UNIQUE_ID) || (op == OP_PARAM_RD) ||
                  (op == OP_RDSR)) && (cnt >= fise_data_start(op))) begin
      link.dev_io_oe <= 4'h2; // [R7] [R16]
      link.dev_io_o <= {2'h0, sbyte[3'h7 - idx[2:0]], 1'b0};
    end else begin
      link.dev_io_oe <= 4'h0;
      link.dev_io_o <= 4'h0;
    end
  end

  // Select and arming flags cross into the sys domain; all stable at select rise
  always_ff @(posedge i_clk_sys) begin
    sync1 <= {erase_sel, arm_erase, arm_wren, link.cs_n};
    sync2 <= sync1;
    cs_prev <= i_rst ? 1'b1 : sync2[0];
  end
  assign cs_rise = sync2[0] && !cs_prev;
  assign erase_start = cs_rise && sync2[2] && write_permit_latch && !busy &&
                       !lock[2'(sync2[4:3] - 2'h1)]; // [R9] [R11] [R15]
  assign erase_done = busy && (timer == 32'h0000_0000);

  // Self-timed erase cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy <= 1'b0;
      timer <= 32'h0000_0000;
      erase_reg <= 2'h1;
    end else if (erase_start) begin
      busy <= 1'b1; // [R12] [R13]
      timer <= 32'(P_ERASE_CYCLES - 1);
      erase_reg <= sync2[4:3];
    end else if (erase_done) begin
      busy <= 1'b0; // [R13]
    end else if (busy) begin
      timer <= timer - 32'h0000_0001;
    end
  end

  // Write permit latch: set by write enable, cleared at erase end [R14]
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      write_permit_latch <= 1'b0;
    end else if (cs_rise && sync2[1] && !busy) begin
      write_permit_latch <= 1'b1;
    end else if (erase_done) begin
      write_permit_latch <= 1'b0; // [R14]
    end
  end

  // Lock bits only ever accumulate until i_rst clears them [R15]
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lock <= 3'h0;
    end else begin
      lock <= lock | i_otp_lock_bits; // [R15]
    end
  end

  // Sweep fills the chosen register with ones at the start of the cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sweeping <= 1'b0;
      sweep <= 8'h00;
    end else if (erase_start) begin
      sweeping <= 1'b1;
      sweep <= 8'h00;
    end else if (sweeping) begin
      sweeping <= (sweep != 8'hff);
      sweep <= sweep + 8'h01;
    end
  end

  // Security array; preload blocked while an erase runs
  always_ff @(posedge i_clk_sys) begin
    if (sweeping) begin
      sec_mem[{2'(erase_reg - 2'h1), sweep}] <= ERASED_BYTE; // [R18]
    end else if (i_sec_we && !busy && (i_sec_addr[9:8] != 2'h3)) begin
      sec_mem[i_sec_addr] <= i_sec_wdata;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sec_rdata <= 8'h00;
      o_busy <= 1'b0;
      o_write_permit_latch <= 1'b0;
      o_otp_lock_bits <= 3'h0;
    end else begin
      o_sec_rdata <= (i_sec_addr[9:8] == 2'h3) ? ERASED_BYTE : sec_mem[i_sec_addr];
      o_busy <= busy;
      o_write_permit_latch <= write_permit_latch;
      o_otp_lock_bits <= lock;
    end
  end
endmodule : fise_flash_dev

/* rtl/fise_pkg.sv */
// Shared constants for the flash identification / security erase link.
// Assumes a 125 MHz system clock on both ends and SPI mode 0 on the link.
package fise_pkg;
  // Opcodes handled by the device
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_QUAD_ID = 8'h94;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] OP_STD_ID = 8'h9f;
  localparam logic [7:0] OP_PARAM_RD = 8'h5a;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  // Link clock counts (rising edges before data or before a legal end)
  localparam logic [15:0] CLK_OPCODE = 16'h0008;
  localparam logic [15:0] CLK_QUAD_ADDR_END = 16'h000e;
  localparam logic [15:0] CLK_QUAD_MODE_END = 16'h0010;
  localparam logic [15:0] CLK_QUAD_DATA = 16'h0014;
  localparam logic [15:0] CLK_ADDR_END = 16'h0020;
  localparam logic [15:0] CLK_SERIAL_DATA = 16'h0028;
  localparam logic [3:0] QUAD_MODE_HI = 4'hf;
  // Status byte layout
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  // Security registers
  localparam int SEC_REG_BYTES = 256;
  localparam int SEC_REG_COUNT = 3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int SEC_ERASE_TIME_US = 50000;
  localparam int SEC_ERASE_CYCLES = SEC_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam logic [2:0] HOST_HALF_LAST = 3'h3;
  localparam logic [2:0] HOST_PER_LAST = 3'h7;
  localparam logic [2:0] HOST_SAMPLE_PH = 3'h6;
  // Host register word offsets and fields
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_ADDR = 4'h1;
  localparam logic [3:0] HREG_STATUS = 4'h2;
  localparam logic [3:0] HREG_RX_LO = 4'h3;
  localparam logic [3:0] HREG_RX_HI = 4'h4;
  localparam int CMD_NRD_LSB = 8;

  // Link clocks that precede data (or the whole frame for write-type commands)
  function automatic logic [15:0] fise_data_start(input logic [7:0] op);
    case (op)
      OP_QUAD_ID: fise_data_start = CLK_QUAD_DATA;
      OP_UNIQUE_ID, OP_PARAM_RD: fise_data_start = CLK_SERIAL_DATA;
      OP_SEC_ERASE: fise_data_start = CLK_ADDR_END;
      default: fise_data_start = CLK_OPCODE;
    endcase
  endfunction : fise_data_start
endpackage : fise_pkg

/* rtl/fise_link_if.sv */
// Link between the flash device and its host controller.
// Resolves the four shared data lines; undriven lines float high (pull-ups).
`timescale 1ns/1ps
interface fise_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Device drive wins a clash so a protocol error shows as wrong data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = dev_io_oe[i] ? dev_io_o[i] : (host_io_oe[i] ? host_io_o[i] : 1'b1);
    end
  end

  modport dev (input sclk, cs_n, io, output dev_io_o, dev_io_oe);
  modport host (output sclk, cs_n, host_io_o, host_io_oe, input io);
endinterface : fise_link_if

/* rtl/fise_spi_host.sv */
// Host controller end: runs one link command per write of the command register while idle.
// Makes the link clock by dividing i_clk_sys by eight; mode 0 framing.
`timescale 1ns/1ps
module fise_spi_host (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic [3:0] i_addr, // Register word offset
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after i_rd
  fise_link_if.host link // Link to device
);
  import fise_pkg::*;

  typedef enum logic [1:0] {FISE_IDLE, FISE_SETUP, FISE_SHIFT, FISE_HOLD} fise_state_e;
  fise_state_e state;
  logic [7:0] op;
  logic [3:0] nrd;
  logic [23:0] addr;
  logic [63:0] rx;
  logic [15:0] k;
  logic [15:0] total;
  logic [2:0] ph;
  logic [3:0] io_s1, io_s2;
  logic [7:0] drv;

  // Pin drive for link clock n: {oe, value}
  function automatic logic [7:0] host_drive(input logic [7:0] o, input logic [15:0] n);
    if (n < CLK_OPCODE) begin
      host_drive = {4'h1, 3'h0, o[3'(4'h7 - n[3:0])]};
    end else if ((o == OP_QUAD_ID) && (n < CLK_QUAD_ADDR_END)) begin
      host_drive = 8'hf0; // [R1]
    end else if ((o == OP_QUAD_ID) && (n < CLK_QUAD_MODE_END)) begin
      host_drive = (n == CLK_QUAD_ADDR_END) ? {4'hf, QUAD_MODE_HI} : 8'hf0; // [R4]
    end else if (((o == OP_PARAM_RD) || (o == OP_SEC_ERASE)) && (n < CLK_ADDR_END)) begin
      host_drive = {4'h1, 3'h0, addr[5'(16'h001f - n)]}; // [R8] [R10]
    end else begin
      host_drive = 8'h00;
    end
  endfunction : host_drive

  assign drv = host_drive(op, (state == FISE_IDLE) ? 16'h0000 : k + 16'h0001);

  // Data lines from the device pass two flops
  always_ff @(posedge i_clk_sys) begin
    io_s1 <= link.io;
    io_s2 <= io_s1;
  end

  // Frame sequencer; erase frames end exactly after the address only when nrd is zero, else eight clocks per nrd later [R11]
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= FISE_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.host_io_o <= 4'h0;
      link.host_io_oe <= 4'h0;
      k <= 16'h0000;
      ph <= 3'h0;
      total <= 16'h0000;
      op <= 8'h00;
      nrd <= 4'h0;
    end else begin
      case (state)
        FISE_IDLE: begin
          if (i_wr && (i_addr == HREG_CMD)) begin
            op <= i_wdata[7:0];
            nrd <= i_wdata[CMD_NRD_LSB +: 4];
            total <= fise_data_start(i_wdata[7:0]) +
                     ((i_wdata[7:0] == OP_QUAD_ID) ? {11'h000, i_wdata[CMD_NRD_LSB +: 4], 1'b0} :
                      {9'h000, i_wdata[CMD_NRD_LSB +: 4], 3'h0});
            k <= 16'h0000;
            ph <= 3'h0;
            state <= FISE_SETUP;
          end
        end
        FISE_SETUP: begin
          link.cs_n <= 1'b0;
          {link.host_io_oe, link.host_io_o} <= host_drive(op, 16'h0000);
          ph <= ph + 3'h1;
          if (ph == HOST_HALF_LAST) begin
            ph <= 3'h0;
            state <= (total == 16'h0000) ? FISE_HOLD : FISE_SHIFT;
          end
        end
        FISE_SHIFT: begin
          ph <= ph + 3'h1;
          if (ph == HOST_HALF_LAST) begin
            link.sclk <= 1'b1;
          end
          if (ph == HOST_PER_LAST) begin
            link.sclk <= 1'b0; // Host changes its lines on the falling edge
            {link.host_io_oe, link.host_io_o} <= drv;
            k <= k + 16'h0001;
            if (k == total - 16'h0001) begin
              state <= FISE_HOLD;
            end
          end
        end
        FISE_HOLD: begin
          link.cs_n <= 1'b1;
          link.host_io_oe <= 4'h0;
          ph <= ph + 3'h1;
          if (ph == HOST_PER_LAST) begin
            state <= FISE_IDLE; // Select stays high a full link period
          end
        end
        default: state <= FISE_IDLE;
      endcase
    end
  end

  // Receive shifter samples mid high phase, after the device drove on falling [R2] [R5]
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx <= 64'h0000_0000_0000_0000;
    end else if (i_wr && (i_addr == HREG_CMD) && (state == FISE_IDLE)) begin
      rx <= 64'h0000_0000_0000_0000;
    end else if ((state == FISE_SHIFT) && (ph == HOST_SAMPLE_PH) && (k >= fise_data_start(op))) begin
      rx <= (op == OP_QUAD_ID) ? {rx[59:0], io_s2} : {rx[62:0], io_s2[1]};
    end
  end

  // Address register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr <= 24'h00_0000;
    end else if (i_wr && (i_addr == HREG_ADDR)) begin
      addr <= i_wdata[23:0];
    end
  end

  // Read port; data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        HREG_CMD: o_rdata <= {20'h0_0000, nrd, op};
        HREG_ADDR: o_rdata <= {8'h00, addr};
        HREG_STATUS: o_rdata <= {31'h0000_0000, state != FISE_IDLE};
        HREG_RX_LO: o_rdata <= rx[31:0];
        HREG_RX_HI: o_rdata <= rx[63:32];
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : fise_spi_host

/* test/fise_link_checker.sv */
// Concurrent checks on the link between host and flash device.
// Assumes sclk and cs_n are launched from i_clk_sys, so sampling on it is safe.
`timescale 1ns/1ps
module fise_link_checker (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic sclk, // Link clock
  input wire logic cs_n, // Select, active low
  input wire logic [3:0] host_io_o, // Host drive
  input wire logic [3:0] host_io_oe, // Host enable
  input wire logic [3:0] dev_io_o, // Device drive
  input wire logic [3:0] dev_io_oe, // Device enable
  input wire logic [3:0] io // Resolved lines
);
  logic sclk_q;
  logic [7:0] clk_cnt;
  logic [7:0] op;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // Count link rising edges per frame and capture the opcode off io0
  always_ff @(posedge i_clk_sys) begin
    sclk_q <= sclk;
    if (i_rst || cs_n) begin
      clk_cnt <= 8'h00;
      op <= 8'h00;
    end else if (sclk && !sclk_q) begin
      clk_cnt <= (clk_cnt == 8'hff) ? clk_cnt : clk_cnt + 8'h01; // Saturate, no wrap
      if (clk_cnt < 8'h08) op <= {op[6:0], io[0]};
    end
  end

  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock not low while deselected");
  a_dev_quiet_idle: assert property (cs_n |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_drive_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(dev_io_o) |-> $fell(sclk))
    else $error("device data changed off a falling edge");
  a_enable_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(dev_io_oe) |-> $fell(sclk))
    else $error("device enable changed off a falling edge");
  a_param_dummy_wait: assert property (
    op == 8'h5a && clk_cnt >= 8'h08 && clk_cnt < 8'h28 |-> dev_io_oe == 4'h0)
    else $error("parameter data before clock 40");
  a_quad_id_wait: assert property (
    op == 8'h94 && clk_cnt >= 8'h08 && clk_cnt < 8'h14 |-> dev_io_oe == 4'h0)
    else $error("quad id data before address and mode done");
  a_quad_id_drive: assert property (!cs_n && op == 8'h94 && clk_cnt > 8'h14 |-> dev_io_oe == 4'hf)
    else $error("quad id not driven on four lines");
  a_std_id_drive: assert property (!cs_n && op == 8'h9f && clk_cnt > 8'h08 |-> dev_io_oe == 4'h2)
    else $error("standard id not driven on serial out");
  a_erase_silent: assert property (op == 8'h44 && clk_cnt >= 8'h08 |-> dev_io_oe == 4'h0)
    else $error("device drives during erase command");
  // Both ends driving one line would hide a turnaround slip behind the resolver
  a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("host and device drive the same line");
  // Fifteenth rising edge carries the upper mode nibble, all four lines high
  a_mode_upper_ones: assert property (
    op == 8'h94 && clk_cnt == 8'h0e && sclk && !sclk_q |-> host_io_oe == 4'hf && host_io_o == 4'hf)
    else $error("quad mode upper nibble not all ones");

  c_quad_long: cover property (op == 8'h94 && clk_cnt == 8'h1c);
  c_param_data: cover property (op == 8'h5a && clk_cnt == 8'h30);
  c_erase_end: cover property (op == 8'h44 && clk_cnt == 8'h20 ##1 cs_n);
endmodule : fise_link_checker

/* test/flash_id_and_security_erase_bench.sv */
// Self-checking bench: host controller and flash device joined by the link.
// Drives the host register port and the device preload port; erase time shortened.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module flash_id_and_security_erase_bench;
  import fise_pkg::*;
  localparam logic [7:0] MFR = 8'h5c; // Arbitrary value
  localparam logic [7:0] DEV = 8'h16; // Arbitrary value
  localparam logic [7:0] MEM = 8'h40; // Arbitrary value
  localparam logic [7:0] CAP = 8'h17; // Arbitrary value
  localparam logic [63:0] UID = 64'h0123456789abcdef; // Arbitrary value
  // Malformed erase addresses: bit 14, middle nibble, upper byte, register zero
  localparam logic [23:0] BAD_ADDR [4] = '{24'h004000, 24'h001100, 24'h011000, 24'h000000};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic [2:0] lock_in = 3'h4;
  logic sec_we = 1'b0;
  logic [9:0] sec_addr = 10'h000;
  logic [7:0] sec_wdata = 8'h00;
  logic [7:0] sec_rdata;
  logic busy;
  logic write_permit_latch;
  logic [2:0] lock_out;
  logic [63:0] rx;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  fise_link_if u_fise_link_if ();
  fise_spi_host u_fise_spi_host (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .link(u_fise_link_if.host));
  fise_flash_dev #(.P_ERASE_CYCLES(400), .P_MFR_ID(MFR), .P_DEV_ID(DEV), .P_MEM_TYPE(MEM),
    .P_CAPACITY(CAP), .P_UNIQUE_ID(UID)) u_fise_flash_dev (.i_clk_sys(clk), .i_rst(rst),
    .i_otp_lock_bits(lock_in), .i_sec_we(sec_we), .i_sec_addr(sec_addr),
    .i_sec_wdata(sec_wdata), .o_sec_rdata(sec_rdata), .o_busy(busy),
    .o_write_permit_latch(write_permit_latch), .o_otp_lock_bits(lock_out), .link(u_fise_link_if.dev));
  fise_link_checker u_fise_link_checker (.i_clk_sys(clk), .i_rst(rst),
    .sclk(u_fise_link_if.sclk), .cs_n(u_fise_link_if.cs_n),
    .host_io_o(u_fise_link_if.host_io_o), .host_io_oe(u_fise_link_if.host_io_oe),
    .dev_io_o(u_fise_link_if.dev_io_o), .dev_io_oe(u_fise_link_if.dev_io_oe),
    .io(u_fise_link_if.io));

  // 125 MHz system clock
  always #4 clk = ~clk;

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // One link frame; the poll is bounded so a stuck host is reported, not waited on
  task automatic cmd(input logic [7:0] op, input logic [3:0] nrd, input logic [23:0] a);
    logic [31:0] s;
    int n;
    wr(HREG_ADDR, {8'h00, a});
    wr(HREG_CMD, {20'h0, nrd, op});
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 2000) begin
      rd(HREG_STATUS, s);
      n++;
    end
    `CHK("frame done", 1'b0, s[0])
    rd(HREG_RX_LO, s);
    rx[31:0] = s;
    rd(HREG_RX_HI, s);
    rx[63:32] = s;
  endtask : cmd

  task automatic sec_rd(input logic [9:0] a);
    @(posedge clk);
    sec_addr <= a;
    repeat (2) @(posedge clk);
    #1;
  endtask : sec_rd

  initial begin
    int w;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("busy after reset", 1'b0, busy)
    `CHK("latch after reset", 1'b0, write_permit_latch)
    // Preload byte 5 of every security register with zero
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      sec_we <= 1'b1;
      sec_addr <= {r[1:0], 8'h05};
      @(posedge clk);
      sec_we <= 1'b0;
    end
    cmd(OP_STD_ID, 4'h3, 24'h0);
    `CHK("std id", {MFR, MEM, CAP}, rx[23:0])
    cmd(OP_QUAD_ID, 4'h4, 24'h0);
    `CHK("quad id", {MFR, DEV, MFR, DEV}, rx[31:0])
    cmd(OP_UNIQUE_ID, 4'h8, 24'h0);
    `CHK("unique id", UID, rx)
    $display("test id reads done");
    cmd(OP_PARAM_RD, 4'h4, 24'h000000);
    `CHK("param head", 32'h53464450, rx[31:0])
    cmd(OP_PARAM_RD, 4'h2, 24'h000005);
    `CHK("param offset", 16'h0100, rx[15:0])
    cmd(OP_PARAM_RD, 4'h2, 24'h0000ff);
    `CHK("param wrap", 16'hff53, rx[15:0])
    cmd(OP_PARAM_RD, 4'h1, 24'h000100);
    `CHK("param high addr", 8'hff, rx[7:0])
    $display("test parameter reads done");
    cmd(OP_SEC_ERASE, 4'h0, 24'h001000);
    `CHK("erase no latch", 1'b0, busy)
    cmd(OP_WREN, 4'h0, 24'h0);
    `CHK("latch set", 1'b1, write_permit_latch)
    // Malformed register addresses are refused and leave the latch alone
    for (int i = 0; i < 4; i++) begin
      cmd(OP_SEC_ERASE, 4'h0, BAD_ADDR[i]);
      `CHK("erase bad addr", 1'b0, busy)
    end
    // Eight extra clocks after the address: select rises off the legal boundary
    cmd(OP_SEC_ERASE, 4'h1, 24'h001000);
    `CHK("erase off boundary", 1'b0, busy)
    cmd(OP_SEC_ERASE, 4'h0, 24'h003000);
    `CHK("erase locked", 1'b0, busy)
    sec_rd(10'h205);
    `CHK("locked byte kept", 8'h00, sec_rdata)
    $display("test refused erases done");
    cmd(OP_SEC_ERASE, 4'h0, 24'h0010a7);
    `CHK("erase started", 1'b1, busy)
    cmd(OP_RDSR, 4'h1, 24'h0);
    `CHK("status in erase", 8'h03, rx[7:0])
    w = 0;
    while (busy !== 1'b0 && w < 1000) begin
      @(posedge clk);
      #1 w++;
    end
    `CHK("erase ended", 1'b0, busy)
    `CHK("latch cleared", 1'b0, write_permit_latch)
    cmd(OP_RDSR, 4'h1, 24'h0);
    `CHK("status after", 8'h00, rx[7:0])
    sec_rd(10'h005);
    `CHK("erased byte", ERASED_BYTE, sec_rdata)
    sec_rd(10'h105);
    `CHK("other reg kept", 8'h00, sec_rdata)
    lock_in <= 3'h0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("lock sticky", 3'h4, lock_out)
    $display("test erase done");
    complete_run();
  end
endmodule : flash_id_and_security_erase_bench
